/* File: inc/hscr_pkg.sv */
// Shared constants and types for the hub string and port configuration registers.
`default_nettype none
package hscr_pkg;
  // ---------------------------------------------------------------
  // Register indices; the APB byte address is four times the index.
  // ---------------------------------------------------------------
  localparam logic [7:0]  IDX_PROD_LEN   = 8'h14;
  localparam logic [7:0]  IDX_SER_LEN    = 8'h15;
  localparam logic [7:0]  IDX_MAKER_BASE = 8'h16;
  localparam logic [7:0]  IDX_MAKER_LAST = 8'h53;
  localparam logic [7:0]  IDX_PROD_BASE  = 8'h54;
  localparam logic [7:0]  IDX_PROD_LAST  = 8'h91;
  localparam logic [7:0]  IDX_SER_BASE   = 8'h92;
  localparam logic [7:0]  IDX_SER_LAST   = 8'hCF;
  localparam logic [7:0]  IDX_CHARGE     = 8'hD0;
  localparam logic [7:0]  IDX_UP_BOOST   = 8'hF6;
  localparam logic [7:0]  IDX_DN_BOOST   = 8'hF8;
  // ---------------------------------------------------------------
  // Sizes, limits, field positions and reset values.
  // ---------------------------------------------------------------
  localparam int unsigned TEXT_BYTES     = 62;
  localparam int unsigned TEXT_IDX_W     = 6;
  localparam int unsigned APB_AW         = 12;
  localparam logic [7:0]  MAX_CHARS      = 8'h1F;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [31:0] BUS_RESET      = 32'h0000_0000;
  localparam int unsigned CHG_P1_BIT     = 1;
  localparam int unsigned CHG_P2_BIT     = 2;
  localparam int unsigned UP_LVL_LSB     = 0;
  localparam int unsigned DN_P1_LSB      = 0;
  localparam int unsigned DN_P2_LSB      = 2;
  // Four-level signalling drive strength.
  typedef enum logic [1:0] {DRIVE_NORMAL, DRIVE_PLUS4, DRIVE_PLUS8, DRIVE_PLUS12} hscr_drive_type;
endpackage
`default_nettype wire

/* File: inc/hscr_acc_if.sv */
// Register access carrier from the APB slave to the storage modules.
`timescale 1ns/10ps
`default_nettype none
interface hscr_acc_if;
  logic       wrStb;
  logic [7:0] idx;
  logic [7:0] wdata;
  modport ctrl (output wrStb, output idx, output wdata);
  modport regs (input wrStb, input idx, input wdata);
endinterface
`default_nettype wire

/* File: hw/hscr_text_store.sv */
// One byte-wide descriptor text store with a register port and a core read port.
`timescale 1ns/10ps
`default_nettype none
module hscr_text_store
  import hscr_pkg::*;
#(
  parameter logic [7:0]  BASE  = IDX_MAKER_BASE,
  parameter int unsigned DEPTH = TEXT_BYTES
)
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  hscr_acc_if.regs                   acc,
  input  wire logic [TEXT_IDX_W-1:0] coreIdx,
  output logic      [7:0]            coreByte,
  output logic                       rdHit,
  output logic      [7:0]            rdByte
);
  logic [7:0]            mem [DEPTH];
  logic [7:0]            off8;
  logic [TEXT_IDX_W-1:0] off;
  logic                  coreOk;

  // Each index holds one byte, so a character's low byte sits below its high byte.
  assign off8   = acc.idx - BASE;
  assign off    = off8[TEXT_IDX_W-1:0];
  assign rdHit  = (acc.idx >= BASE) && (off8 < 8'(DEPTH));
  assign rdByte = rdHit ? mem[off] : REG_RESET;
  assign coreOk = {2'h0, coreIdx} < 8'(DEPTH);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= REG_RESET;
    end
    else if (acc.wrStb && rdHit)
      mem[off] <= acc.wdata;
  end

  // Core read is registered; indices past the end read as zero.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      coreByte <= REG_RESET;
    else
      coreByte <= coreOk ? mem[coreIdx] : REG_RESET;
  end
endmodule // hscr_text_store
`default_nettype wire

/* File: hw/hscr_port_ctrl.sv */
// Charging enables and drive strength boost settings for the hub ports.
`timescale 1ns/10ps
`default_nettype none
module hscr_port_ctrl
  import hscr_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           sys_rst,
  hscr_acc_if.regs            acc,
  output logic                rdHit,
  output logic      [7:0]     rdByte,
  output logic      [1:0]     chargeSupportEn,
  output hscr_drive_type      upstreamDriveLevel,
  output hscr_drive_type      portOneDriveLevel,
  output hscr_drive_type      portTwoDriveLevel
);
  logic           hitChg;
  logic           hitUp;
  logic           hitDn;
  logic [1:0]     chgQ;
  hscr_drive_type upQ;
  hscr_drive_type dn1Q;
  hscr_drive_type dn2Q;

  // Address decode of the three port registers.
  assign hitChg = acc.idx == IDX_CHARGE;
  assign hitUp  = acc.idx == IDX_UP_BOOST;
  assign hitDn  = acc.idx == IDX_DN_BOOST;
  assign rdHit  = hitChg | hitUp | hitDn;

  assign rdByte = hitChg ? {5'h00, chgQ[1], chgQ[0], 1'b0} :
                  hitUp  ? {6'h00, upQ} :
                  hitDn  ? {4'h0, dn2Q, dn1Q} : REG_RESET;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      chgQ <= 2'h0;
    else if (acc.wrStb && hitChg)
      chgQ <= {acc.wdata[CHG_P2_BIT], acc.wdata[CHG_P1_BIT]};
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      upQ <= DRIVE_NORMAL;
    else if (acc.wrStb && hitUp)
      upQ <= hscr_drive_type'(acc.wdata[UP_LVL_LSB +: 2]);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dn1Q <= DRIVE_NORMAL;
      dn2Q <= DRIVE_NORMAL;
    end
    else if (acc.wrStb && hitDn)
    begin
      dn1Q <= hscr_drive_type'(acc.wdata[DN_P1_LSB +: 2]);
      dn2Q <= hscr_drive_type'(acc.wdata[DN_P2_LSB +: 2]);
    end
  end

  assign chargeSupportEn    = chgQ;
  assign upstreamDriveLevel = upQ;
  assign portOneDriveLevel  = dn1Q;
  assign portTwoDriveLevel  = dn2Q;
endmodule // hscr_port_ctrl
`default_nettype wire

/* File: hw/hscr_regs.sv */
// APB register slave for the hub string descriptors and port configuration.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module hscr_regs
  import hscr_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_AW-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic      [31:0]           prdata,
  output logic                       pslverr,
  input  wire logic [TEXT_IDX_W-1:0] coreByteIdx,
  output logic      [7:0]            makerTextByte,
  output logic      [7:0]            productTextByte,
  output logic      [7:0]            serialTextByte,
  output logic      [7:0]            productTextCount,
  output logic      [7:0]            serialTextCount,
  output logic      [1:0]            chargeSupportEn,
  output hscr_drive_type             upstreamDriveLevel,
  output hscr_drive_type             portOneDriveLevel,
  output hscr_drive_type             portTwoDriveLevel
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  hscr_acc_if acc ();

  logic        setupPh;
  logic        accessPh;
  logic        aligned;
  logic        inRange;
  logic [7:0]  byteIdx;
  logic        hitProdLen;
  logic        hitSerLen;
  logic        makerHit;
  logic        prodHit;
  logic        serHit;
  logic        portHit;
  logic [7:0]  makerRd;
  logic [7:0]  prodRd;
  logic [7:0]  serRd;
  logic [7:0]  portRd;
  logic [7:0]  localRd;
  logic [7:0]  rdByte;
  logic        mapped;
  logic        lenBad;
  logic        wrOk;
  logic [7:0]  prodLenQ;
  logic [7:0]  serLenQ;
  logic [31:0] prdataQ;
  logic [31:0] prdataD;

  // ---------------------------------------------------------------
  // APB phase and address decode
  // ---------------------------------------------------------------
  // The slave never inserts wait states, so every access ends in its first cycle.
  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign pready   = 1'b1;
  assign aligned  = paddr[1:0] == 2'h0;
  assign inRange  = paddr[APB_AW-1:10] == 2'h0;
  assign byteIdx  = paddr[9:2];

  assign hitProdLen = byteIdx == IDX_PROD_LEN;
  assign hitSerLen  = byteIdx == IDX_SER_LEN;

  // Unaligned or unknown addresses answer with an error and store nothing.
  assign mapped = aligned & inRange &
                  (hitProdLen | hitSerLen | makerHit | prodHit | serHit | portHit);

  assign lenBad  = pwrite & (hitProdLen | hitSerLen) & (pwdata[7:0] > MAX_CHARS);
  assign pslverr = accessPh & (~mapped | lenBad);

  // only the low byte lane stores
  assign wrOk = accessPh & pwrite & mapped & ~lenBad & pstrb[0];

  // Requests travel to the storage modules over the access carrier.
  assign acc.wrStb = wrOk;
  assign acc.idx   = byteIdx;
  assign acc.wdata = pwdata[7:0];

  // ---------------------------------------------------------------
  // String length registers
  // ---------------------------------------------------------------
  // length register storage
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prodLenQ <= REG_RESET;
      serLenQ  <= REG_RESET;
    end
    else if (wrOk)
    begin
      if (hitProdLen)
        prodLenQ <= pwdata[7:0];
      if (hitSerLen)
        serLenQ <= pwdata[7:0];
    end
  end

  assign productTextCount = prodLenQ;
  assign serialTextCount  = serLenQ;

  // ---------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------
  // Sources drive zero when not addressed, so an OR gathers them.
  assign localRd = hitProdLen ? prodLenQ : (hitSerLen ? serLenQ : REG_RESET);
  assign rdByte  = localRd | makerRd | prodRd | serRd | portRd;
  assign prdataD = (setupPh && !pwrite && mapped) ? {24'h00_0000, rdByte} : BUS_RESET;

  // Read data is caught in the setup cycle so it comes from a flop in the access cycle.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      prdataQ <= BUS_RESET;
    else if (setupPh)
      prdataQ <= prdataD;
  end

  assign prdata = prdataQ;

  // ---------------------------------------------------------------
  // Descriptor text stores
  // ---------------------------------------------------------------
  // maker text store
  hscr_text_store #(
    .BASE  (IDX_MAKER_BASE),
    .DEPTH (TEXT_BYTES)
  ) u_maker (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .acc      (acc.regs),
    .coreIdx  (coreByteIdx),
    .coreByte (makerTextByte),
    .rdHit    (makerHit),
    .rdByte   (makerRd)
  );

  hscr_text_store #(
    .BASE  (IDX_PROD_BASE),
    .DEPTH (TEXT_BYTES)
  ) u_product (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .acc      (acc.regs),
    .coreIdx  (coreByteIdx),
    .coreByte (productTextByte),
    .rdHit    (prodHit),
    .rdByte   (prodRd)
  );

  hscr_text_store #(
    .BASE  (IDX_SER_BASE),
    .DEPTH (TEXT_BYTES)
  ) u_serial (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .acc      (acc.regs),
    .coreIdx  (coreByteIdx),
    .coreByte (serialTextByte),
    .rdHit    (serHit),
    .rdByte   (serRd)
  );

  // ---------------------------------------------------------------
  // Port charging and drive settings
  // ---------------------------------------------------------------
  hscr_port_ctrl u_port (
    .clk                (clk),
    .sys_rst            (sys_rst),
    .acc                (acc.regs),
    .rdHit              (portHit),
    .rdByte             (portRd),
    .chargeSupportEn    (chargeSupportEn),
    .upstreamDriveLevel (upstreamDriveLevel),
    .portOneDriveLevel  (portOneDriveLevel),
    .portTwoDriveLevel  (portTwoDriveLevel)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_len_refuse: assert property (
    (accessPh && pwrite && aligned && inRange && hitProdLen && pwdata[7:0] > MAX_CHARS)
    |-> pslverr ##1 $stable(productTextCount))
    else $error("Oversize product length was not refused.");

  chk_len_store: assert property (
    (accessPh && pwrite && pstrb[0] && aligned && inRange && hitSerLen && pwdata[7:0] <= MAX_CHARS)
    |=> serialTextCount == $past(pwdata[7:0]))
    else $error("Legal serial length was not stored.");

  chk_maker_first: assert property (
    (wrOk && byteIdx == IDX_MAKER_BASE) ##1 (coreByteIdx == 6'h00)
    |=> makerTextByte == $past(pwdata[7:0], 2))
    else $error("Maker text first byte not at base index.");

  chk_prod_last: assert property (
    (wrOk && byteIdx == IDX_PROD_LAST) ##1 (coreByteIdx == 6'(TEXT_BYTES - 1))
    |=> productTextByte == $past(pwdata[7:0], 2))
    else $error("Product text last byte not at last index.");

  chk_ser_range: assert property (
    (accessPh && !pwrite && aligned && inRange && byteIdx >= IDX_SER_BASE && byteIdx <= IDX_SER_LAST)
    |-> !pslverr)
    else $error("Serial text index answered with an error.");

  chk_charge_bits: assert property (
    (wrOk && byteIdx == IDX_CHARGE)
    |=> chargeSupportEn == {$past(pwdata[CHG_P2_BIT]), $past(pwdata[CHG_P1_BIT])})
    else $error("Charge enables do not match written bits.");

  chk_up_level: assert property (
    (wrOk && byteIdx == IDX_UP_BOOST)
    |=> upstreamDriveLevel == hscr_drive_type'($past(pwdata[1:0])))
    else $error("Upstream drive level does not match write.");

  chk_dn_levels: assert property (
    (wrOk && byteIdx == IDX_DN_BOOST)
    |=> portTwoDriveLevel == hscr_drive_type'($past(pwdata[3:2]))
        && portOneDriveLevel == hscr_drive_type'($past(pwdata[1:0])))
    else $error("Downstream drive levels do not match write.");

  chk_rsvd_zero: assert property (
    (setupPh && !pwrite && aligned && inRange && byteIdx == IDX_CHARGE)
    |=> prdata[7:3] == 5'h00 && prdata[0] == 1'b0 && prdata[31:8] == 24'h00_0000)
    else $error("Reserved charge enable bits read nonzero.");

  // ---------------------------------------------------------------
  // Coverage of main scenarios
  // ---------------------------------------------------------------
  cov_maker_write: cover property (wrOk && makerHit);
  cov_ser_read: cover property (accessPh && !pwrite && serHit && prdata != BUS_RESET);
  cov_len_refuse: cover property (accessPh && lenBad);
  cov_boost_max: cover property (portTwoDriveLevel == DRIVE_PLUS12);
endmodule // hscr_regs
`default_nettype wire

/* File: verif/hscr_cfg_master.sv */
// Partner model: the external configuration master speaking APB.
`timescale 1ns/10ps
`default_nettype none
module hscr_cfg_master
  import hscr_pkg::*;
(
  input  wire logic              clk,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [APB_AW-1:0] paddr,
  output logic      [31:0]       pwdata,
  output logic      [3:0]        pstrb,
  input  wire logic              pready,
  input  wire logic [31:0]       prdata,
  input  wire logic              pslverr
);
  // The bus is idle at time zero.
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // One transfer; gap + 1 idle cycles first so the master can be slow as well as prompt.
  // A released bus shows inverted address and data so stale values are never trusted.
  task automatic xfer(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d,
                      input logic [3:0] s, input int gap, output logic [31:0] r, output logic e);
    repeat (gap + 1) @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // hscr_cfg_master
`default_nettype wire

/* File: verif/test_hub_string_and_port_config_regs.sv */
// Self-checking bench for the hub string and port configuration registers.
`timescale 1ns/10ps
`default_nettype none
module test_hub_string_and_port_config_regs;
  import hscr_pkg::*;
  logic                  clk;
  logic                  sys_rst;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [APB_AW-1:0]     paddr;
  logic [31:0]           pwdata;
  logic [3:0]            pstrb;
  logic                  pready;
  logic [31:0]           prdata;
  logic                  pslverr;
  logic [TEXT_IDX_W-1:0] coreByteIdx;
  logic [7:0]            makerTextByte;
  logic [7:0]            productTextByte;
  logic [7:0]            serialTextByte;
  logic [7:0]            productTextCount;
  logic [7:0]            serialTextCount;
  logic [1:0]            chargeSupportEn;
  hscr_drive_type        upstreamDriveLevel;
  hscr_drive_type        portOneDriveLevel;
  hscr_drive_type        portTwoDriveLevel;
  logic [7:0]            expReg [256];
  logic [15:0]           ch;
  int                    failures;
  int                    tests_run;
  int                    cycles;

  hscr_regs dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
    .pslverr, .coreByteIdx, .makerTextByte, .productTextByte, .serialTextByte, .productTextCount,
    .serialTextCount, .chargeSupportEn, .upstreamDriveLevel, .portOneDriveLevel, .portTwoDriveLevel);
  hscr_cfg_master m (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr);

  // ---------------------------------------------------------------
  // Clock, timeout and helpers
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The run needs about 3000 cycles; over six times that means a hang.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end

  // Reserved bits are dropped, so the expected read-back keeps only live fields.
  function automatic logic [7:0] keep(input logic [7:0] i, input logic [7:0] d);
    case (i)
      IDX_CHARGE:   return d & 8'h06;
      IDX_UP_BOOST: return d & 8'h03;
      IDX_DN_BOOST: return d & 8'h0F;
      default:      return d;
    endcase
  endfunction

  function automatic logic bad(input logic [7:0] i, input logic w, input logic [7:0] v);
    logic ok;
    ok = (i >= IDX_PROD_LEN && i <= IDX_CHARGE) || i == IDX_UP_BOOST || i == IDX_DN_BOOST;
    return !ok || (w && (i == IDX_PROD_LEN || i == IDX_SER_LEN) && v > MAX_CHARS);
  endfunction

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic access(input logic [APB_AW-1:0] a, input logic w, input logic [31:0] d,
                        input logic [3:0] s, input logic e, input logic [7:0] x);
    logic [31:0] r;
    logic        f;
    m.xfer(w, a, d, s, $urandom_range(2), r, f);
    cmp({7'h00, f}, {7'h00, e});
    cmp({7'h00, pready}, 8'h01);
    if (!w)
    begin
      cmp(r[7:0], x);
      cmp(r[15:8] | r[23:16] | r[31:24], 8'h00);
    end
  endtask

  task automatic put(input logic [7:0] i, input logic [7:0] v);
    logic e;
    e = bad(i, 1'b1, v);
    access({2'b00, i, 2'b00}, 1'b1, {24'($urandom), v}, 4'hF, e, 8'h00);
    if (!e) expReg[i] = keep(i, v);
  endtask

  task automatic get(input logic [7:0] i);
    access({2'b00, i, 2'b00}, 1'b0, 32'h0000_0000, 4'h0, bad(i, 1'b0, 8'h00), expReg[i]);
  endtask

  // Registered outputs move at the edge that ends the access, so look half a cycle later.
  task automatic outs();
    @(negedge clk);
    cmp(productTextCount, expReg[IDX_PROD_LEN]);
    cmp(serialTextCount, expReg[IDX_SER_LEN]);
    cmp({6'h00, chargeSupportEn}, {6'h00, expReg[IDX_CHARGE][2:1]});
    cmp({6'h00, upstreamDriveLevel}, {6'h00, expReg[IDX_UP_BOOST][1:0]});
    cmp({6'h00, portOneDriveLevel}, {6'h00, expReg[IDX_DN_BOOST][1:0]});
    cmp({6'h00, portTwoDriveLevel}, {6'h00, expReg[IDX_DN_BOOST][3:2]});
  endtask

  // Index k is taken at the second edge; the byte is looked at once it has settled.
  task automatic core(input int k);
    @(posedge clk);
    coreByteIdx <= TEXT_IDX_W'(k);
    @(posedge clk);
    @(negedge clk);
    cmp(makerTextByte, k < 62 ? expReg[IDX_MAKER_BASE + k] : 8'h00);
    cmp(productTextByte, k < 62 ? expReg[IDX_PROD_BASE + k] : 8'h00);
    cmp(serialTextByte, k < 62 ? expReg[IDX_SER_BASE + k] : 8'h00);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    coreByteIdx = '0;
    failures = 0;
    tests_run = 0;
    cycles = 0;
    foreach (expReg[i]) expReg[i] = 8'h00;
    void'($urandom(90383));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 16; i < 256; i++) get(8'(i));
    outs();
    $display("test reset and map sweep done");
    for (int s = 0; s < 3; s++)
      for (int c = 0; c < 31; c++)
      begin
        ch = 16'($urandom);
        put(IDX_MAKER_BASE + 8'(TEXT_BYTES * s + 2 * c), ch[7:0]);
        put(IDX_MAKER_BASE + 8'(TEXT_BYTES * s + 2 * c + 1), ch[15:8]);
      end
    for (int k = 0; k < 64; k++) core(k);
    // Corner case: the core already points at the last product byte while it is written.
    @(posedge clk);
    coreByteIdx <= TEXT_IDX_W'(TEXT_BYTES - 1);
    put(IDX_PROD_LAST, 8'($urandom));
    core(TEXT_BYTES - 1);
    $display("test text stores done");
    put(IDX_PROD_LEN, MAX_CHARS);
    put(IDX_SER_LEN, 8'h20);
    for (int n = 0; n < 12; n++) put(IDX_PROD_LEN + 8'(n % 2), 8'($urandom_range(45)));
    get(IDX_PROD_LEN);
    get(IDX_SER_LEN);
    outs();
    $display("test length limits done");
    for (int lv = 0; lv < 4; lv++)
    begin
      put(IDX_UP_BOOST, 8'hFC | 8'(lv));
      put(IDX_DN_BOOST, 8'hF0 | 8'(lv << 2) | 8'(3 - lv));
      put(IDX_CHARGE, 8'hF9 | 8'(lv << 1));
      outs();
    end
    for (int n = 0; n < 12; n++) put(n % 3 == 0 ? IDX_CHARGE : (n % 3 == 1 ? IDX_UP_BOOST : IDX_DN_BOOST), 8'($urandom));
    outs();
    $display("test port settings done");
    access({2'b00, IDX_UP_BOOST, 2'b01}, 1'b1, 32'h0000_00FF, 4'hF, 1'b1, 8'h00);
    access({2'b01, IDX_UP_BOOST, 2'b00}, 1'b1, 32'h0000_00FF, 4'hF, 1'b1, 8'h00);
    access({2'b00, IDX_CHARGE, 2'b00}, 1'b1, {24'h00_0000, ~expReg[IDX_CHARGE]}, 4'hE, 1'b0, 8'h00);
    for (int i = 16; i < 256; i++) get(8'(i));
    outs();
    $display("test refusals and final sweep done");
    conclude();
  end
endmodule // test_hub_string_and_port_config_regs
`default_nettype wire
